// File: hdl/cpcs_map.svh
// constants for the charger pin control and status block
`ifndef CPCS_MAP_SVH
`define CPCS_MAP_SVH
// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CPCS_CLK_HZ          50000000
`define CPCS_INT_PULSE_US    256
`define CPCS_INT_PULSE_CYC   ((`CPCS_CLK_HZ / 1000000) * `CPCS_INT_PULSE_US)
`define CPCS_BLINK_HZ        1
`define CPCS_BLINK_HALF_CYC  (`CPCS_CLK_HZ / (2 * `CPCS_BLINK_HZ))
`define CPCS_ON_DEGLITCH     5000
`define CPCS_RST_DEGLITCH    20000
`define CPCS_SWITCH_RST      40000
// ---------------------------------------------------------------
// field values and limits
// ---------------------------------------------------------------
`define CPCS_CHG_CFG_ON      2'h1
`define CPCS_GOOD_MIN_MA     12'h01e
`define CPCS_USB_HI_MA       12'h1f4
`define CPCS_USB_LO_MA       12'h064
`define CPCS_CNT_W           26
`endif

// File: hdl/cpcs_pkg.sv
// types for the charger pin control and status block
package cpcs_pkg;
	// analog comparator results that qualify the input source
	typedef struct packed {
		logic above_lockout;
		logic below_ovp;
		logic above_sleep;
	} cpcs_src_t;
	// register bits that arrive from the register bank
	typedef struct packed {
		logic [2:0] input_limit_field;
		logic [1:0] charge_config_field;
	} cpcs_cfg_t;
	typedef enum logic [1:0] {CPCS_SW_ON, CPCS_SW_SHIP, CPCS_SW_RESET} cpcs_sw_state_t;
endpackage : cpcs_pkg

// File: hdl/cpcs_button.sv
// button deglitch and battery switch control
`include "cpcs_map.svh"
module cpcs_button #(
	parameter int ON_DEGLITCH  = `CPCS_ON_DEGLITCH,
	parameter int RST_DEGLITCH = `CPCS_RST_DEGLITCH,
	parameter int SWITCH_RST   = `CPCS_SWITCH_RST
) (
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	input  wire logic ship_exit_button_in,
	input  wire logic source_present_in,
	input  wire logic ship_request_in,
	output logic      battery_switch_on_out
);
	import cpcs_pkg::*;
	cpcs_sw_state_t          state_q;
	logic [`CPCS_CNT_W-1:0]  low_cnt_q;
	logic [`CPCS_CNT_W-1:0]  off_cnt_q;
	wire                     on_hit  = low_cnt_q == (`CPCS_CNT_W)'(ON_DEGLITCH);
	wire                     rst_hit = low_cnt_q == (`CPCS_CNT_W)'(RST_DEGLITCH);
	wire                     off_end = off_cnt_q >= (`CPCS_CNT_W)'(SWITCH_RST - 1);
	// count how long the button has been held low since its fall
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_cnt_q <= '0;
		end else begin
			if (ship_exit_button_in)
				low_cnt_q <= '0;
			else if (low_cnt_q < (`CPCS_CNT_W)'(RST_DEGLITCH))
				low_cnt_q <= low_cnt_q + 1'b1; // saturates at RST_DEGLITCH, so on_hit fires once but rst_hit stays set for a long hold
		end
	end
	// switch state: ship exit on deglitched low, reset pulse without source
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q   <= CPCS_SW_ON;
			off_cnt_q <= '0;
		end else begin
			unique case (state_q)
				CPCS_SW_ON: begin
					off_cnt_q <= '0;
					if (ship_request_in)
						state_q <= CPCS_SW_SHIP;
					else if (rst_hit && !source_present_in && !ship_exit_button_in)
						state_q <= CPCS_SW_RESET; // [RULE12]
				end
				CPCS_SW_SHIP: begin
					if (on_hit && !ship_exit_button_in)
						state_q <= CPCS_SW_ON; // [RULE11]
				end
				CPCS_SW_RESET: begin
					off_cnt_q <= off_cnt_q + 1'b1;
					if (off_end)
						state_q <= CPCS_SW_ON; // [RULE12] [RULE14]
				end
			endcase
		end
	end
	assign battery_switch_on_out = (state_q == CPCS_SW_ON);
	a_reset_off_len: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(state_q == CPCS_SW_RESET) |-> (state_q == CPCS_SW_RESET) [*8]) // [RULE12]
		else $error("switch reset too short");
	a_ship_exit: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_q == CPCS_SW_SHIP && ship_exit_button_in) |=> state_q != CPCS_SW_ON) // [RULE11]
		else $error("ship exit without button low");
endmodule : cpcs_button

// File: hdl/cpcs_top.sv
// charger pin control and status top
// Notes on behaviour
// RULE1 - source select high means usb host port, low means wall adapter
// RULE2 - input good pulled low only with valid input window and limit above 30 mA
// RULE3 - status low while charging, released high when done or disabled
// RULE4 - any fault makes the status output blink at 1 Hz
// RULE5 - status change or fault gives one 256 us low interrupt pulse; code ignores one that comes while a pulse runs
// RULE6 - buck with usb host: boost select high gives 500 mA, low 100 mA
// RULE7 - boost only with boost config bit set and boost select high
// RULE8 - charging only with config field 01 and charge enable pin low
// RULE9 - effective limit is lower of resistor cap and register field limit
// RULE10 - thermistor out of window suspends charging or disables boost
// RULE11 - button low past turn-on deglitch turns switch on, leaving ship mode
// RULE12 - no source, button low past reset deglitch pulses switch off
// RULE13 - interrupt pulse starts at once on a fault, no host read needed; code starts none for a fault during a pulse
// RULE14 - deglitch and switch reset times are cycle count parameters
// RULE15 - register bits arrive as plain synchronous inputs
`include "cpcs_map.svh"
module cpcs_top #(
	parameter int ON_DEGLITCH  = `CPCS_ON_DEGLITCH,
	parameter int RST_DEGLITCH = `CPCS_RST_DEGLITCH,
	parameter int SWITCH_RST   = `CPCS_SWITCH_RST,
	parameter int BLINK_HALF   = `CPCS_BLINK_HALF_CYC
) (
	input  wire logic                sys_clk_in,
	input  wire logic                reset_n_in,
	input  wire logic                source_select_in,
	input  wire logic                boost_select_in,
	input  wire logic                charge_enable_n_in,
	input  wire logic                thermistor_window_ok_in,
	input  wire logic                ship_exit_button_in,
	input  wire logic                ship_request_in,
	input  wire cpcs_pkg::cpcs_src_t source_in,
	input  wire cpcs_pkg::cpcs_cfg_t cfg_in,
	input  wire logic                boost_config_bit_in,
	input  wire logic [11:0]         resistor_current_cap_in,
	input  wire logic                charging_active_in,
	input  wire logic                fault_in,
	output logic                     input_good_n_out,
	output logic                     input_good_n_oe_out,
	output logic                     charge_status_out,
	output logic                     charge_status_oe_out,
	output logic                     interrupt_n_out,
	output logic                     interrupt_n_oe_out,
	output logic [11:0]              input_current_limit_out,
	output logic                     usb_source_out,
	output logic                     boost_mode_out,
	output logic                     charge_enable_out,
	output logic                     battery_switch_on_out
);
	import cpcs_pkg::*;
	// ---------------------------------------------------------------
	// registered copies of pins and register bits
	// ---------------------------------------------------------------
	cpcs_cfg_t              cfg_q;
	cpcs_src_t              src_q;
	logic                   boost_cfg_q;
	logic                   psel_q;
	logic                   otg_q;
	logic                   ce_n_q;
	logic                   therm_ok_q;
	logic                   fault_q;
	logic                   chg_act_q;
	logic [11:0]            cap_q;
	logic [11:0]            limit_q;
	logic                   good_q;
	logic                   boost_q;
	logic                   chg_q;
	logic                   stat_low_q;
	logic                   blink_q;
	logic [`CPCS_CNT_W-1:0] blink_cnt_q;
	logic [15:0]            int_cnt_q;
	logic                   int_low_q;
	logic                   sw_on_q;
	logic                   prev_evt_q;
	logic [2:0]             prev_sum_q;
	logic                   sw_on;
	// ---------------------------------------------------------------
	// decoding
	// ---------------------------------------------------------------
	// register limit table and usb default limit
	logic [11:0] field_ma;
	always_comb begin
		unique case (cfg_q.input_limit_field)
			3'h0: field_ma = 12'h064;
			3'h1: field_ma = 12'h096;
			3'h2: field_ma = 12'h1f4;
			3'h3: field_ma = 12'h384;
			3'h4: field_ma = 12'h3e8;
			3'h5: field_ma = 12'h5dc;
			3'h6: field_ma = 12'h7d0;
			3'h7: field_ma = 12'hbb8;
		endcase
	end
	wire        boost_d = boost_cfg_q && otg_q && therm_ok_q; // [RULE7] [RULE10]
	wire        chg_d   = (cfg_q.charge_config_field == `CPCS_CHG_CFG_ON) && !ce_n_q
		&& therm_ok_q; // [RULE8] [RULE10]
	wire [11:0] usb_ma  = otg_q ? `CPCS_USB_HI_MA : `CPCS_USB_LO_MA; // [RULE6]
	wire [11:0] reg_ma  = (psel_q && !boost_q && usb_ma < field_ma) ? usb_ma : field_ma;
	wire [11:0] limit_d = (cap_q < reg_ma) ? cap_q : reg_ma; // [RULE9]
	wire        good_d  = src_q.above_lockout && src_q.below_ovp && src_q.above_sleep
		&& (limit_q > `CPCS_GOOD_MIN_MA); // [RULE2]
	wire        blink_w = blink_cnt_q >= (`CPCS_CNT_W)'(BLINK_HALF - 1);
	wire [2:0]  sum_d   = {good_q, chg_q && chg_act_q, boost_q};
	wire        evt     = (sum_d != prev_sum_q) || (fault_q && !prev_evt_q); // [RULE13]
	// ---------------------------------------------------------------
	// input sampling
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_q       <= '0;
			src_q       <= '0;
			boost_cfg_q <= 1'b0;
			psel_q      <= 1'b0;
			otg_q       <= 1'b0;
			ce_n_q      <= 1'b1;
			therm_ok_q  <= 1'b0;
			fault_q     <= 1'b0;
			chg_act_q   <= 1'b0;
			cap_q       <= '0;
		end else begin
			cfg_q       <= cfg_in; // [RULE15]
			src_q       <= source_in;
			boost_cfg_q <= boost_config_bit_in; // [RULE15]
			psel_q      <= source_select_in; // [RULE1]
			otg_q       <= boost_select_in;
			ce_n_q      <= charge_enable_n_in;
			therm_ok_q  <= thermistor_window_ok_in;
			fault_q     <= fault_in;
			chg_act_q   <= charging_active_in;
			cap_q       <= resistor_current_cap_in;
		end
	end
	// ---------------------------------------------------------------
	// mode, limit and status
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			limit_q    <= '0;
			good_q     <= 1'b0;
			boost_q    <= 1'b0;
			chg_q      <= 1'b0;
			stat_low_q <= 1'b0;
			sw_on_q    <= 1'b1;
		end else begin
			limit_q    <= limit_d;
			good_q     <= good_d;
			boost_q    <= boost_d;
			chg_q      <= chg_d && !boost_d;
			stat_low_q <= fault_q ? blink_q : (chg_q && chg_act_q); // [RULE3] [RULE4]
			sw_on_q    <= sw_on;
		end
	end
	// blink timer, free running while a fault stands
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (!fault_q) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (blink_w) begin
			blink_cnt_q <= '0;
			blink_q     <= !blink_q; // [RULE4]
		end else begin
			blink_cnt_q <= blink_cnt_q + 1'b1;
		end
	end
	// interrupt pulse, started by a new event while idle; events during a pulse are ignored
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			int_cnt_q  <= '0;
			int_low_q  <= 1'b0;
			prev_evt_q <= 1'b0;
			prev_sum_q <= '0;
		end else begin
			prev_evt_q <= fault_q;
			prev_sum_q <= sum_d;
			if (evt && !int_low_q) begin
				int_low_q <= 1'b1; // [RULE5] [RULE13]
				int_cnt_q <= 16'(`CPCS_INT_PULSE_CYC - 1);
			end else if (int_low_q) begin
				if (int_cnt_q == 16'h0000)
					int_low_q <= 1'b0; // [RULE5]
				else
					int_cnt_q <= int_cnt_q - 1'b1;
			end
		end
	end
	// battery switch and ship button handling
	cpcs_button #(
		.ON_DEGLITCH  (ON_DEGLITCH),
		.RST_DEGLITCH (RST_DEGLITCH),
		.SWITCH_RST   (SWITCH_RST)
	) u_button (
		.sys_clk_in            (sys_clk_in),
		.reset_n_in            (reset_n_in),
		.ship_exit_button_in   (ship_exit_button_in),
		.source_present_in     (src_q.above_lockout),
		.ship_request_in       (ship_request_in),
		.battery_switch_on_out (sw_on)
	);
	// ---------------------------------------------------------------
	// outputs, open drain pins drive low when enabled
	// ---------------------------------------------------------------
	assign input_good_n_out        = 1'b0;
	assign input_good_n_oe_out     = good_q;
	assign charge_status_out       = 1'b0;
	assign charge_status_oe_out    = stat_low_q;
	assign interrupt_n_out         = 1'b0;
	assign interrupt_n_oe_out      = int_low_q;
	assign input_current_limit_out = limit_q;
	assign usb_source_out          = psel_q;
	assign boost_mode_out          = boost_q;
	assign charge_enable_out       = chg_q;
	assign battery_switch_on_out   = sw_on_q;
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_int_pulse_len: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(int_low_q) |-> int_low_q [*8] ##1 (int_cnt_q == 16'(`CPCS_INT_PULSE_CYC - 9))) // [RULE5]
		else $error("interrupt pulse length wrong");
	a_fault_int_fast: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(fault_q) |-> ##[0:1] int_low_q) // [RULE13]
		else $error("fault interrupt late");
	a_boost_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		boost_q |-> $past(boost_cfg_q) && $past(otg_q) && $past(therm_ok_q)) // [RULE7]
		else $error("boost without enables");
	a_charge_gate: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		chg_q |-> $past(cfg_q.charge_config_field) == 2'h1 && !$past(ce_n_q)) // [RULE8]
		else $error("charge without enables");
	a_therm_suspend: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		!therm_ok_q |=> !chg_q && !boost_q) // [RULE10]
		else $error("thermistor fault ignored");
	a_limit_min: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		##1 limit_q <= $past(cap_q)) // [RULE9]
		else $error("limit above resistor cap");
	a_good_window: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		good_q |-> $past(src_q.above_lockout) && $past(src_q.below_ovp)
		&& $past(src_q.above_sleep) && $past(limit_q) > 12'h01e) // [RULE2]
		else $error("input good without window");
	a_stat_charge: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		!fault_q && !$past(fault_q) && chg_q && chg_act_q |=> stat_low_q) // [RULE3]
		else $error("status not low while charging");
	a_usb_limit: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		psel_q && !boost_q && !otg_q && cap_q >= 12'h064 && $stable(psel_q) && $stable(otg_q)
		&& $stable(cap_q) && $stable(cfg_q) && $stable(boost_q) |=> limit_q == 12'h064) // [RULE6]
		else $error("usb low limit wrong");
	c_fault_blink: cover property (@(posedge sys_clk_in) fault_q && $rose(blink_q));
	c_int_pulse: cover property (@(posedge sys_clk_in) $fell(int_low_q));
	c_boost_on: cover property (@(posedge sys_clk_in) $rose(boost_q));
	c_switch_reset: cover property (@(posedge sys_clk_in) $fell(sw_on_q));
endmodule : cpcs_top

// File: verif/cpcs_host_model.sv
// host side model that drives the control pins of the block
module cpcs_host_model (
	input  wire logic sys_clk_in,
	output logic      source_select_out,
	output logic      boost_select_out,
	output logic      charge_enable_n_out,
	output logic      ship_exit_button_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------
	// pins are driven from time zero, never left floating
	initial begin
		source_select_out    = 1'b1;
		boost_select_out     = 1'b0;
		charge_enable_n_out  = 1'b1;
		ship_exit_button_out = 1'b1;
	end
	// level change just after a falling edge
	task automatic set_pins(input logic usb, input logic boost, input logic ce_n);
		@(negedge sys_clk_in);
		source_select_out   = usb;
		boost_select_out    = boost;
		charge_enable_n_out = ce_n;
	endtask
	// button held low for a count of cycles, then back to idle high
	task automatic press(input int cycles);
		@(negedge sys_clk_in);
		ship_exit_button_out = 1'b0;
		repeat (cycles) @(negedge sys_clk_in);
		ship_exit_button_out = 1'b1;
	endtask
endmodule // cpcs_host_model

// File: verif/cpcs_top_tb_top.sv
// self-checking testbench for the charger pin control and status block
`include "cpcs_map.svh"
module cpcs_top_tb_top;
	import cpcs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ON_DG = 20;
	localparam int RST_DG = 40;
	localparam int SW_RST = 30;
	localparam int BLINK = 50;
	localparam logic [11:0] LIM [8] = '{12'h064, 12'h096, 12'h1f4, 12'h384,
		12'h3e8, 12'h5dc, 12'h7d0, 12'hbb8};
	logic clk, rst_n, ssel, bsel, ce_n, button, therm_ok, ship_req, boost_cfg, chg_act, fault;
	cpcs_src_t src;
	cpcs_cfg_t cfg;
	logic [11:0] cap, limit;
	logic good_o, good_oe, stat_o, stat_oe, int_o, int_oe, usb, boost, chg, sw_on;
	logic good_pin, stat_pin, int_pin, exp_b;
	int fails = 0;
	int comparisons = 0;
	// ---------------------------------------------------------------
	// clock, pins with pull-ups, instances
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// open drain lines float high when released
	assign good_pin = good_oe ? good_o : 1'b1;
	assign stat_pin = stat_oe ? stat_o : 1'b1;
	assign int_pin  = int_oe ? int_o : 1'b1;
	cpcs_host_model cpcs_host_model_i (.sys_clk_in(clk), .source_select_out(ssel),
		.boost_select_out(bsel), .charge_enable_n_out(ce_n), .ship_exit_button_out(button));
	cpcs_top #(.ON_DEGLITCH(ON_DG), .RST_DEGLITCH(RST_DG), .SWITCH_RST(SW_RST),
		.BLINK_HALF(BLINK)) cpcs_top_i (.sys_clk_in(clk), .reset_n_in(rst_n),
		.source_select_in(ssel), .boost_select_in(bsel), .charge_enable_n_in(ce_n),
		.thermistor_window_ok_in(therm_ok), .ship_exit_button_in(button),
		.ship_request_in(ship_req), .source_in(src), .cfg_in(cfg),
		.boost_config_bit_in(boost_cfg), .resistor_current_cap_in(cap),
		.charging_active_in(chg_act), .fault_in(fault), .input_good_n_out(good_o),
		.input_good_n_oe_out(good_oe), .charge_status_out(stat_o),
		.charge_status_oe_out(stat_oe), .interrupt_n_out(int_o),
		.interrupt_n_oe_out(int_oe), .input_current_limit_out(limit),
		.usb_source_out(usb), .boost_mode_out(boost), .charge_enable_out(chg),
		.battery_switch_on_out(sw_on));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic settle();
		repeat (6) @(negedge clk);
	endtask
	task automatic conclude();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// limit from field, resistor cap and usb select pin
	task automatic test_limit();
		logic [11:0] e;
		for (int i = 0; i < 17; i++) begin
			cpcs_host_model_i.set_pins(i < 16, i[3], 1'b1);
			cfg.input_limit_field = i[2:0];
			cap = i[0] ? 12'h7d0 : 12'h12c;
			settle();
			e = (LIM[i[2:0]] < cap) ? LIM[i[2:0]] : cap;
			if (i < 16 && e > (i[3] ? 12'h1f4 : 12'h064)) e = i[3] ? 12'h1f4 : 12'h064;
			check("limit", limit, e);
			check("usb source", usb, i < 16);
		end
	endtask
	// boost and charge gating, thermistor window
	task automatic test_modes();
		for (int i = 0; i < 64; i++) begin
			cpcs_host_model_i.set_pins(1'b0, i[1], i[4]);
			boost_cfg = i[0];
			cfg.charge_config_field = i[3:2];
			therm_ok = !i[5];
			settle();
			exp_b = i[0] & i[1] & !i[5];
			check("boost", boost, exp_b);
			check("charge", chg, i[3:2] == 2'h1 && !i[4] && !i[5] && !exp_b);
		end
		therm_ok = 1'b1;
		cpcs_host_model_i.set_pins(1'b1, 1'b1, 1'b1);
		boost_cfg = 1'b1;
		cfg.input_limit_field = 3'h6;
		cap = 12'h7d0;
		settle();
		check("boost usb", boost, 1'b1);
		check("boost limit", limit, 12'h7d0);
		boost_cfg = 1'b0;
	endtask
	// input good window and 30 mA boundary
	task automatic test_good();
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			src = cpcs_src_t'(i[2:0]);
			cap = i[3] ? 12'h01f : 12'h01e;
			settle();
			check("input good", good_pin, !(i[2:0] == 3'h7 && i[3]));
		end
		cap = 12'h7d0;
	endtask
	// charge status, fault interrupt pulse and blink
	task automatic test_status();
		int k;
		logic s;
		cpcs_host_model_i.set_pins(1'b0, 1'b0, 1'b0);
		cfg.charge_config_field = 2'h1;
		chg_act = 1'b1;
		settle();
		check("charge enabled", chg, 1'b1);
		check("status charging", stat_pin, 1'b0);
		@(negedge clk) chg_act = 1'b0;
		settle();
		check("status done", stat_pin, 1'b1);
		k = 0;
		while (int_pin !== 1'b1 && k < 13000) begin
			k++;
			@(negedge clk);
		end
		check("interrupt idle", int_pin, 1'b1);
		@(negedge clk) fault = 1'b1;
		k = 0;
		while (int_pin !== 1'b0 && k < 4) begin
			k++;
			@(negedge clk);
		end
		check("interrupt start", k <= 3, 1'b1);
		k = 0;
		while (int_pin === 1'b0 && k < 13000) begin
			k++;
			@(negedge clk);
		end
		check("interrupt width", k, `CPCS_INT_PULSE_CYC);
		for (int j = 0; j < 2; j++) begin
			s = stat_pin;
			repeat (BLINK) @(negedge clk);
			check("status blink", stat_pin, !s);
		end
		fault = 1'b0;
	endtask
	// ship mode exit and battery switch reset
	task automatic test_button();
		@(negedge clk) ship_req = 1'b1;
		settle();
		@(negedge clk) ship_req = 1'b0;
		cpcs_host_model_i.press(ON_DG / 2);
		settle();
		check("switch short press", sw_on, 1'b0);
		cpcs_host_model_i.press(ON_DG + 5);
		settle();
		check("switch ship exit", sw_on, 1'b1);
		src = 3'h7;
		cpcs_host_model_i.press(RST_DG + 10);
		settle();
		check("switch with source", sw_on, 1'b1);
		src = 3'h0;
		fork
			cpcs_host_model_i.press(RST_DG + 10);
			begin
				repeat (RST_DG + 6) @(negedge clk);
				check("switch reset off", sw_on, 1'b0);
			end
		join
		repeat (10) @(negedge clk);
		check("switch still off", sw_on, 1'b0);
		repeat (20) @(negedge clk);
		check("switch back on", sw_on, 1'b1);
	endtask
	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		therm_ok = 1'b1;
		ship_req = 1'b0;
		boost_cfg = 1'b0;
		chg_act = 1'b0;
		fault = 1'b0;
		src = 3'h7;
		cfg = '0;
		cap = 12'h7d0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		test_limit();
		test_modes();
		test_good();
		test_status();
		test_button();
		conclude();
	end
	// cuts a hang short well past the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		conclude();
	end
endmodule // cpcs_top_tb_top
